//--- design/sequencer_pkg.sv
// Constants, field layouts and carrier types for the load-switch enable sequencer
package sequencer_pkg;

  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFFSET_MASK_A = 8'h22;
  localparam logic [7:0] OFFSET_SOURCE_THRESHOLD = 8'h23;
  localparam logic [7:0] OFFSET_EDGE_DELAYS = 8'h24;
  localparam logic [7:0] RESET_MASK_A = 8'h00;
  localparam logic [7:0] RESET_SOURCE_THRESHOLD = 8'h80;
  localparam logic [7:0] RESET_EDGE_DELAYS = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MASK_LIN_A_TWO_BIT = 7;
  localparam int MASK_CONV_A_ONE_BIT = 6;
  localparam int MASK_STEP_DOWN_HI = 5;
  localparam int MASK_STEP_DOWN_LO = 0;
  localparam int MASK_SHARED_RAIL_BIT = 1;
  localparam int MASK_LIN_A_THREE_BIT = 0;
  localparam int THRESHOLD_HI = 6;
  localparam int THRESHOLD_LO = 5;
  localparam int SOURCE_HI = 4;
  localparam int SOURCE_LO = 2;
  localparam int TURN_OFF_HI = 5;
  localparam int TURN_OFF_LO = 3;
  localparam int TURN_ON_HI = 2;
  localparam int TURN_ON_LO = 0;

  // ----------------------------------------
  // Enable source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_CONTROL_ONE = 3'h0,
    SRC_CONTROL_TWO = 3'h1,
    SRC_CONTROL_FIVE = 3'h2,
    SRC_CONTROL_FOUR = 3'h3,
    SRC_CONTROL_THREE = 3'h4,
    SRC_THREE_AND_FOUR = 3'h5,
    SRC_CONTROL_SIX = 3'h6,
    SRC_ALWAYS_ON = 3'h7
  } enable_source_type;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int MILLISECOND_NS = 1000000;
  localparam int CYCLES_PER_MS = MILLISECOND_NS / CLOCK_PERIOD_NS;
  localparam int COUNT_W = 22;
  localparam int DELAY_MS_W = 7;
  localparam int DELAY_TOLERANCE_PERCENT = 10;

  // Delay code to milliseconds; code 7 is 64 ms for both edges
  function automatic logic [DELAY_MS_W-1:0] delay_ms(input logic [2:0] code);
    logic [DELAY_MS_W-1:0] ms;
    ms = 7'h00;
    case (code)
      3'h0: ms = 7'h00;
      3'h1: ms = 7'h02;
      3'h2: ms = 7'h04;
      3'h3: ms = 7'h08;
      3'h4: ms = 7'h10;
      3'h5: ms = 7'h18;
      3'h6: ms = 7'h20;
      default: ms = 7'h40;
    endcase
    return ms;
  endfunction

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic lin_a_two;
    logic conv_a_one;
    logic [5:0] step_down;
    logic shared_rail;
    logic lin_a_three;
  } rail_good_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_write_type;

endpackage

//--- design/two_stage_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module two_stage_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------
  // Per-bit stages
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic first_q;
      logic second_q;
      // First stage feeds only the second stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          first_q <= 1'b0;
          second_q <= 1'b0;
        end else begin
          first_q <= async_in[i];
          second_q <= first_q;
        end
      end
      assign sync_out[i] = second_q;
    end
  endgenerate

endmodule // two_stage_sync

//--- design/edge_delay_timer.sv
// Level follower that delays rising and falling edges by separate counts
`timescale 1ns/1ps
module edge_delay_timer #(
  parameter int COUNT_W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level and delays in cycles
  input wire logic level_in,
  input wire logic [COUNT_W-1:0] rise_cycles,
  input wire logic [COUNT_W-1:0] fall_cycles,
  // Delayed level
  output logic level_q
);

  logic level_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [COUNT_W-1:0] target;

  // Count while input differs from output; a glitch back restarts the wait
  always_comb begin
    level_d = level_q;
    count_d = '0;
    target = level_in ? rise_cycles : fall_cycles;
    if (level_in != level_q) begin
      if (count_d == target || count_q + 1'b1 >= target) begin
        level_d = level_in;
      end else begin
        count_d = count_q + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
      count_q <= '0;
    end else begin
      level_q <= level_d;
      count_q <= count_d;
    end
  end

endmodule // edge_delay_timer

//--- design/load_switch_enable_sequencer.sv
// Enable qualification, edge delays and register file of one load-switch rail
`timescale 1ns/1ps

// Behaviour
// - Bit 7 of the mask register at 0 makes linear regulator A2 power good part of the enable.
// - Bit 6 of the mask register at 0 makes converter A1 power good part of the enable.
// - Bits 5 to 0 of the mask register at 0 make step-down rails six to one part of the enable.
// - Bit 1 of the source register at 0 makes the shared rail power good part of the enable.
// - Bit 0 of the source register at 0 makes linear regulator A3 power good part of the enable.
// - Source field codes 0 to 6 pick control 1, 2, 5, 4, 3, 3 and 4 together, or 6.
// - Source code 7 feeds a constant one so no control pin is needed.
// - Threshold field codes pick 1.5 V, 1.8 V, 2.5 V and 3.3 V in order.
// - The falling edge is delayed by 0, 2, 4, 8, 16, 24, 32 or 64 ms per the turn-off field.
// - The rising edge is delayed by 0, 2, 4, 8, 16, 24, 32 or 64 ms per the turn-on field.
// - Every programmed delay may deviate from nominal by up to ten percent.
module load_switch_enable_sequencer #(
  parameter int CYCLES_PER_MS = sequencer_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire sequencer_pkg::reg_write_type reg_write,
  input wire logic [7:0] reg_read_addr,
  output logic [7:0] reg_read_data_q,
  // Control pins, index 0 is control one
  input wire logic [5:0] control_in,
  // Power good of the other rails
  input wire sequencer_pkg::rail_good_type rail_good,
  // Switch and monitor outputs
  output logic load_switch_b_one_enable_q,
  output logic qualified_enable_q,
  output logic [1:0] power_good_threshold_field_q
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] mask_a_q;
  logic [7:0] mask_a_d;
  logic [7:0] source_threshold_q;
  logic [7:0] source_threshold_d;
  logic [7:0] edge_delays_q;
  logic [7:0] edge_delays_d;
  logic [7:0] read_d;

  // Writes to the three mapped offsets
  always_comb begin
    mask_a_d = mask_a_q;
    source_threshold_d = source_threshold_q;
    edge_delays_d = edge_delays_q;
    if (reg_write.wr) begin
      if (reg_write.addr == sequencer_pkg::OFFSET_MASK_A) begin
        mask_a_d = reg_write.wdata;
      end else if (reg_write.addr == sequencer_pkg::OFFSET_SOURCE_THRESHOLD) begin
        source_threshold_d = reg_write.wdata;
      end else if (reg_write.addr == sequencer_pkg::OFFSET_EDGE_DELAYS) begin
        edge_delays_d = reg_write.wdata;
      end
    end
  end

  // Read mux, registered; unmapped offsets read zero
  always_comb begin
    read_d = sequencer_pkg::UNMAPPED_READ;
    if (reg_read_addr == sequencer_pkg::OFFSET_MASK_A) begin
      read_d = mask_a_q;
    end else if (reg_read_addr == sequencer_pkg::OFFSET_SOURCE_THRESHOLD) begin
      read_d = source_threshold_q;
    end else if (reg_read_addr == sequencer_pkg::OFFSET_EDGE_DELAYS) begin
      read_d = edge_delays_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_a_q <= sequencer_pkg::RESET_MASK_A;
      source_threshold_q <= sequencer_pkg::RESET_SOURCE_THRESHOLD;
      edge_delays_q <= sequencer_pkg::RESET_EDGE_DELAYS;
      reg_read_data_q <= sequencer_pkg::UNMAPPED_READ;
    end else begin
      mask_a_q <= mask_a_d;
      source_threshold_q <= source_threshold_d;
      edge_delays_q <= edge_delays_d;
      reg_read_data_q <= read_d;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] control_sync;
  sequencer_pkg::rail_good_type good_sync;

  two_stage_sync #(.WIDTH(6)) u_control_sync (
    .clk(clk),
    .rst(rst),
    .async_in(control_in),
    .sync_out(control_sync)
  );

  two_stage_sync #(.WIDTH($bits(sequencer_pkg::rail_good_type))) u_good_sync (
    .clk(clk),
    .rst(rst),
    .async_in(rail_good),
    .sync_out(good_sync)
  );

  // ----------------------------------------
  // Enable qualification
  // ----------------------------------------
  sequencer_pkg::enable_source_type enable_source_field;
  logic selected_control;
  logic goods_met;
  logic qualified_d;
  logic [1:0] threshold_d;

  assign enable_source_field = sequencer_pkg::enable_source_type'(
    source_threshold_q[sequencer_pkg::SOURCE_HI:sequencer_pkg::SOURCE_LO]);

  // Control pin selector
  always_comb begin
    selected_control = 1'b0;
    case (enable_source_field)
      sequencer_pkg::SRC_CONTROL_ONE: selected_control = control_sync[0];
      sequencer_pkg::SRC_CONTROL_TWO: selected_control = control_sync[1];
      sequencer_pkg::SRC_CONTROL_FIVE: selected_control = control_sync[4];
      sequencer_pkg::SRC_CONTROL_FOUR: selected_control = control_sync[3];
      sequencer_pkg::SRC_CONTROL_THREE: selected_control = control_sync[2];
      sequencer_pkg::SRC_THREE_AND_FOUR: selected_control = control_sync[2] & control_sync[3];
      sequencer_pkg::SRC_CONTROL_SIX: selected_control = control_sync[5];
      sequencer_pkg::SRC_ALWAYS_ON: selected_control = 1'b1;
      default: selected_control = 1'b0;
    endcase
  end

  // A set mask bit forces its term true
  always_comb begin
    goods_met = 1'b1;
    goods_met = goods_met &
      (good_sync.lin_a_two | mask_a_q[sequencer_pkg::MASK_LIN_A_TWO_BIT]);
    goods_met = goods_met &
      (good_sync.conv_a_one | mask_a_q[sequencer_pkg::MASK_CONV_A_ONE_BIT]);
    goods_met = goods_met & (&(good_sync.step_down |
      mask_a_q[sequencer_pkg::MASK_STEP_DOWN_HI:sequencer_pkg::MASK_STEP_DOWN_LO]));
    goods_met = goods_met & (good_sync.shared_rail |
      source_threshold_q[sequencer_pkg::MASK_SHARED_RAIL_BIT]);
    goods_met = goods_met & (good_sync.lin_a_three |
      source_threshold_q[sequencer_pkg::MASK_LIN_A_THREE_BIT]);
    qualified_d = selected_control & goods_met;
    threshold_d = source_threshold_q[sequencer_pkg::THRESHOLD_HI:sequencer_pkg::THRESHOLD_LO];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qualified_enable_q <= 1'b0;
      power_good_threshold_field_q <= 2'h0;
    end else begin
      qualified_enable_q <= qualified_d;
      power_good_threshold_field_q <= threshold_d;
    end
  end

  // ----------------------------------------
  // Edge delays
  // ----------------------------------------
  logic [sequencer_pkg::DELAY_MS_W-1:0] turn_on_ms;
  logic [sequencer_pkg::DELAY_MS_W-1:0] turn_off_ms;
  logic [sequencer_pkg::COUNT_W-1:0] rise_cycles;
  logic [sequencer_pkg::COUNT_W-1:0] fall_cycles;

  // Field code to cycles, exact nominal so well inside the tolerance
  always_comb begin
    turn_on_ms = sequencer_pkg::delay_ms(
      edge_delays_q[sequencer_pkg::TURN_ON_HI:sequencer_pkg::TURN_ON_LO]);
    turn_off_ms = sequencer_pkg::delay_ms(
      edge_delays_q[sequencer_pkg::TURN_OFF_HI:sequencer_pkg::TURN_OFF_LO]);
    rise_cycles = sequencer_pkg::COUNT_W'(32'(turn_on_ms) * CYCLES_PER_MS);
    fall_cycles = sequencer_pkg::COUNT_W'(32'(turn_off_ms) * CYCLES_PER_MS);
  end

  // Switch follows the qualified enable after the edge delay
  edge_delay_timer #(.COUNT_W(sequencer_pkg::COUNT_W)) u_delay (
    .clk(clk),
    .rst(rst),
    .level_in(qualified_enable_q),
    .rise_cycles(rise_cycles),
    .fall_cycles(fall_cycles),
    .level_q(load_switch_b_one_enable_q)
  );

endmodule // load_switch_enable_sequencer

//--- bench/sequencer_monitor.sv
// Port-level checker for the load-switch enable sequencer
`timescale 1ns/1ps
module sequencer_monitor #(
  parameter int CYCLES_PER_MS = 40000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire sequencer_pkg::reg_write_type reg_write,
  input wire logic [7:0] reg_read_addr,
  input wire logic [7:0] reg_read_data_q,
  // Switch and monitor outputs
  input wire logic load_switch_b_one_enable_q,
  input wire logic qualified_enable_q,
  input wire logic [1:0] power_good_threshold_field_q
);
  localparam int MS_TABLE [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic [7:0] delay_q, delay_d;
  logic prev_q, prev_d;
  logic [31:0] run_q, run_d;
  logic wr_src;

  // -------------------------------------------
  // Shadow of the delay register and run length of the qualified level
  // -------------------------------------------
  assign wr_src = reg_write.wr && reg_write.addr == 8'h23;
  always_comb begin
    delay_d = delay_q;
    if (reg_write.wr && reg_write.addr == sequencer_pkg::OFFSET_EDGE_DELAYS) delay_d = reg_write.wdata;
    prev_d = qualified_enable_q;
    run_d = (qualified_enable_q == prev_q) ? run_q + 32'h1 : 32'h1;
  end
  // Register the helper state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_q <= sequencer_pkg::RESET_EDGE_DELAYS;
      prev_q <= 1'b0;
      run_q <= 32'h0;
    end else begin
      delay_q <= delay_d;
      prev_q <= prev_d;
      run_q <= run_d;
    end
  end
  // Delay code to cycles, zero code still takes one cycle
  function automatic int cyc(input logic [2:0] c);
    return (MS_TABLE[c] == 0) ? 1 : MS_TABLE[c] * CYCLES_PER_MS;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_rise_delay: assert property ($rose(load_switch_b_one_enable_q) |-> run_q == cyc(delay_q[2:0]))
    else $error("turn-on delay wrong");
  chk_fall_delay: assert property ($fell(load_switch_b_one_enable_q) |-> run_q == cyc(delay_q[5:3]))
    else $error("turn-off delay wrong");
  chk_rise_cause: assert property ($rose(load_switch_b_one_enable_q) |-> qualified_enable_q)
    else $error("switch on without qualified enable");
  chk_fall_cause: assert property ($fell(load_switch_b_one_enable_q) |-> !qualified_enable_q)
    else $error("switch off with qualified enable");
  chk_thresh_write: assert property (wr_src |-> ##2
    power_good_threshold_field_q == $past(reg_write.wdata[6:5], 2))
    else $error("threshold not taken from write");
  chk_thresh_hold: assert property (!wr_src |-> ##2 $stable(power_good_threshold_field_q))
    else $error("threshold changed without write");
  chk_read_back: assert property ((wr_src ##1 !reg_write.wr ##1 (!reg_write.wr &&
    reg_read_addr == 8'h23)) |=> reg_read_data_q == $past(reg_write.wdata, 3))
    else $error("read back differs from write");
  chk_unmapped_read: assert property (!(reg_read_addr inside {8'h22, 8'h23, 8'h24})
    |=> reg_read_data_q == sequencer_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");
  chk_reset_clear: assert property ($fell(rst) |-> !load_switch_b_one_enable_q && !qualified_enable_q)
    else $error("outputs not clear after reset");

  cover property ($rose(load_switch_b_one_enable_q));
  cover property ($fell(load_switch_b_one_enable_q));
  cover property (wr_src);
endmodule // sequencer_monitor

bind load_switch_enable_sequencer sequencer_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) mon (
  .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read_addr(reg_read_addr),
  .reg_read_data_q(reg_read_data_q), .load_switch_b_one_enable_q(load_switch_b_one_enable_q),
  .qualified_enable_q(qualified_enable_q),
  .power_good_threshold_field_q(power_good_threshold_field_q));

//--- bench/control_pin_driver.sv
// System-side model that drives the control pins and the other rails' power good
`timescale 1ns/1ps
module control_pin_driver (
  // Clock
  input wire logic clk,
  // Commanded levels
  input wire logic [5:0] pins_cmd,
  input wire logic [9:0] goods_cmd,
  // Pins toward the sequencer
  output logic [5:0] control_in = 6'h00,
  output sequencer_pkg::rail_good_type rail_good = 10'h000
);
  // Pins change just after a rising edge, like board logic on the same clock
  always @(posedge clk) begin
    control_in <= pins_cmd;
    rail_good <= goods_cmd;
  end
endmodule // control_pin_driver

//--- bench/load_switch_enable_sequencer_tb.sv
// Self-checking bench for the load-switch enable sequencer
`timescale 1ns/1ps
module load_switch_enable_sequencer_tb;
  localparam int CPM = 10;
  localparam int MS_TABLE [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic clk = 1'b0;
  logic rst = 1'b1;
  sequencer_pkg::reg_write_type reg_write = '0;
  logic [7:0] reg_read_addr = 8'h00;
  logic [7:0] reg_read_data_q;
  logic [5:0] pins_cmd = 6'h00;
  logic [9:0] goods_cmd = 10'h000;
  logic [5:0] control_in;
  sequencer_pkg::rail_good_type rail_good;
  logic enable_q, qual_q;
  logic [1:0] thr_q;
  logic [7:0] d;
  logic [9:0] m, g;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 68867;

  // Clock of 25 ns
  always #12.5 clk = ~clk;

  control_pin_driver partner (.clk(clk), .pins_cmd(pins_cmd), .goods_cmd(goods_cmd),
    .control_in(control_in), .rail_good(rail_good));
  load_switch_enable_sequencer #(.CYCLES_PER_MS(CPM)) dut (.clk(clk), .rst(rst),
    .reg_write(reg_write), .reg_read_addr(reg_read_addr), .reg_read_data_q(reg_read_data_q),
    .control_in(control_in), .rail_good(rail_good), .load_switch_b_one_enable_q(enable_q),
    .qualified_enable_q(qual_q), .power_good_threshold_field_q(thr_q));

  // -------------------------------------------
  // Helpers
  // -------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= '{wr: 1'b1, addr: a, wdata: v};
    @(posedge clk);
    reg_write.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_read_addr <= a;
    repeat (2) @(posedge clk);
    #1 check("read data", reg_read_data_q, exp);
  endtask
  // Wait past the pin register, the synchroniser and the qualifier
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  function automatic logic exp_src(input logic [2:0] s, input logic [5:0] p);
    case (s)
      3'h0: return p[0];
      3'h1: return p[1];
      3'h2: return p[4];
      3'h3: return p[3];
      3'h4: return p[2];
      3'h5: return p[2] & p[3];
      3'h6: return p[5];
      default: return 1'b1;
    endcase
  endfunction
  function automatic int exp_cyc(input logic [2:0] c);
    return (MS_TABLE[c] == 0) ? 1 : MS_TABLE[c] * CPM;
  endfunction
  // Move control one and count edges until the switch follows, within ten percent
  task automatic measure(input logic lvl, input int exp);
    int n = 0;
    @(posedge clk);
    pins_cmd[0] <= lvl;
    @(posedge clk);
    #1;
    while (enable_q !== lvl && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    check("edge delay", (n >= exp * 9 / 10 + 3 && n <= exp * 11 / 10 + 3), 1'b1);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end

  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h22, sequencer_pkg::RESET_MASK_A);
    rd(8'h23, sequencer_pkg::RESET_SOURCE_THRESHOLD);
    rd(8'h24, sequencer_pkg::RESET_EDGE_DELAYS);
    wr(8'h30, 8'hFF);
    rd(8'h30, sequencer_pkg::UNMAPPED_READ);
    // Random read-back, every threshold code
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      d[6:5] = i[1:0];
      if (i % 3 == 0) d[0] = 1'b0; // Rail one stays counted so the switch stays off
      wr(8'h22 + 8'(i % 3), d);
      rd(8'h22 + 8'(i % 3), d);
      if (i % 3 == 1) check("threshold", thr_q, d[6:5]);
    end
    // Every enable source with all power good masked
    wr(8'h22, 8'hFF);
    wr(8'h24, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h23, {3'b100, 3'(s), 2'b11});
      for (int t = 0; t < 5; t++) begin
        @(posedge clk);
        pins_cmd <= (t == 0) ? 6'h00 : (t == 1) ? 6'h3F : 6'($random(seed));
        settle();
        check("source", qual_q, exp_src(3'(s), pins_cmd));
      end
    end
    // Each power good alone missing, then random masks and goods
    for (int i = 0; i < 30; i++) begin
      m = 10'($random(seed));
      g = (i < 10) ? ~(10'h001 << i) : 10'($random(seed));
      wr(8'h22, m[9:2]);
      wr(8'h23, {3'b100, 3'b111, m[1:0]});
      @(posedge clk);
      goods_cmd <= g;
      settle();
      check("qualified", qual_q, &(g | m));
      check("enable", enable_q, &(g | m));
    end
    // Edge delays with different codes on the two edges
    wr(8'h22, 8'hFF);
    wr(8'h23, 8'h83);
    @(posedge clk);
    pins_cmd <= 6'h00;
    settle();
    for (int c = 0; c < 8; c++) begin
      wr(8'h24, {2'b00, 3'(c), 3'(7 - c)});
      measure(1'b1, exp_cyc(3'(7 - c)));
      measure(1'b0, exp_cyc(3'(c)));
    end
    // A short drop is cancelled before the turn-off delay runs out
    wr(8'h24, 8'h0A);
    measure(1'b1, exp_cyc(3'h2));
    @(posedge clk);
    pins_cmd[0] <= 1'b0;
    repeat (5) @(posedge clk);
    pins_cmd[0] <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check("cancel", enable_q, 1'b1);
    tally_and_finish();
  end
endmodule // load_switch_enable_sequencer_tb
